/* test/gbs_listener.sv */
// Bus listener model: accepts bytes, logs them, answers parallel poll
`timescale 1ns/10ps
module gbs_listener (
  // Control
  input wire logic i_sys_clk,
  input wire logic i_stall,
  input wire logic i_slow,
  input wire logic [7:0] i_ppr,
  // Bus, low true
  input wire logic i_atn_n,
  input wire logic i_eoi_n,
  input wire logic i_dav_n,
  input wire logic [7:0] i_dio_n,
  output logic o_nrfd_n,
  output logic o_ndac_n,
  output logic [7:0] o_dio_n
);
  logic [9:0] log_q[$];
  // Configured lines pulled low only while ATN and EOI are true
  assign o_dio_n = (!i_atn_n && !i_eoi_n) ? ~i_ppr : 8'hFF;
  initial begin
    o_nrfd_n = 1'b1;
    o_ndac_n = 1'b0;
    forever begin
      @(posedge i_sys_clk iff i_dav_n === 1'b0);
      log_q.push_back({~i_atn_n, ~i_eoi_n, ~i_dio_n});
      #1 o_nrfd_n = 1'b0;
      repeat (i_slow ? 30 : 1) @(posedge i_sys_clk);
      while (i_stall) @(posedge i_sys_clk);
      #1 o_ndac_n = 1'b1;
      @(posedge i_sys_clk iff i_dav_n === 1'b1);
      #1 o_ndac_n = 1'b0;
      o_nrfd_n = 1'b1;
    end
  end
endmodule // gbs_listener

/* test/tb_ieee488_bus_command_sequencer.sv */
// Bench for the bus command sequencer
`timescale 1ns/10ps
`include "gbs_map.svh"
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin errors++; \
  $display("BAD %s exp %0h got %0h", n, e, v); end end
module tb_ieee488_bus_command_sequencer import gbs_pkg::*;;
  logic clk = 0, rst_n = 0, valid = 0, term_wr = 0, eol_wr = 0, d_valid = 0, d_last = 0;
  logic ack = 0, stall = 0, slow = 0;
  gbs_op_type op = OP_LOCKOUT;
  logic [15:0] addr = 0, len = 0, cfg = 0, tmo = 16'h0100, cnt, m_seg, m_off;
  logic [4:0] t_addr = 0;
  logic [1:0] t_mode = 0;
  logic [3:0] e_len = 0;
  logic [63:0] e_str = 0;
  logic [7:0] d_byte = 0, m_data = 0, ppr = 0, pres, dio_n, pdio_n, dio_w;
  logic [2:0] err;
  logic rdy, done, d_rdy, m_req, atn_n, ren_n, eoi_n, dav_n, oe, nrfd_n, ndac_n;
  int errors = 0, num_checks = 0, ce = 0, ca = 0;
  logic [9:0] eq[$];
  logic [7:0] sq[$];
  always #20 clk = ~clk;
  assign dio_w = (oe ? dio_n : 8'hFF) & pdio_n;
  gbs_sequencer #(.TIMEOUT_UNIT_CYCLES(10)) u_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(1'b1),
    .i_cmd_valid(valid), .i_cmd_op(op), .i_cmd_addr(addr), .i_cmd_seg(16'h4000), .i_cmd_len(len),
    .i_cmd_config(cfg), .o_cmd_ready(rdy), .o_done(done), .o_error(err), .o_poll_result(pres),
    .o_count(cnt), .i_my_addr(5'h15), .i_timeout(tmo), .i_term_wr(term_wr), .i_term_addr(t_addr),
    .i_term_mode(t_mode), .i_eol_wr(eol_wr), .i_eol_len(e_len), .i_eol_str(e_str),
    .i_data_valid(d_valid), .i_data_byte(d_byte), .i_data_last(d_last), .o_data_ready(d_rdy),
    .o_mem_req(m_req), .o_mem_seg(m_seg), .o_mem_offset(m_off), .i_mem_ack(ack), .i_mem_data(m_data),
    .o_atn_n(atn_n), .o_ren_n(ren_n), .o_eoi_n(eoi_n), .o_dav_n(dav_n), .o_dio_n(dio_n),
    .o_dio_oe(oe), .i_dio_n(dio_w), .i_nrfd_n(nrfd_n), .i_ndac_n(ndac_n));
  gbs_listener u_bus (.i_sys_clk(clk), .i_stall(stall), .i_slow(slow), .i_ppr(ppr), .i_atn_n(atn_n),
    .i_eoi_n(eoi_n), .i_dav_n(dav_n), .i_dio_n(dio_w), .o_nrfd_n(nrfd_n), .o_ndac_n(ndac_n),
    .o_dio_n(pdio_n));
  // Source segment answers each read with offset plus 0x30
  always @(negedge clk) begin
    ack <= m_req & ~ack;
    m_data <= m_off[7:0] + 8'h30;
    ce <= ce + (eoi_n ? 0 : 1);
    ca <= ca + (atn_n ? 0 : 1);
  end
  task automatic e(logic a, logic i, logic [7:0] b);
    eq.push_back({a, i, b});
  endtask
  task automatic ad(logic [7:0] la);
    e(1, 0, `GBS_CMD_UNL);
    e(1, 0, `GBS_LISTEN_BASE | la);
    e(1, 0, 8'h55);
  endtask
  task automatic cmp(string n);
    `CHK(n, eq.size(), u_bus.log_q.size())
    foreach (eq[k]) if (k < u_bus.log_q.size()) `CHK(n, eq[k], u_bus.log_q[k])
    eq.delete();
  endtask
  task automatic feed();
    while (sq.size() > 0) begin
      @(negedge clk);
      if (d_rdy === 1'b1) begin
        d_byte = sq.pop_front();
        d_last = (sq.size() == 0);
        d_valid = 1;
        @(negedge clk);
        d_valid = 0;
      end
    end
  endtask
  task automatic run(gbs_op_type o, logic [15:0] a, logic [15:0] l, logic [15:0] c);
    int n;
    u_bus.log_q.delete();
    @(negedge clk);
    while (rdy !== 1'b1) @(negedge clk);
    op = o;
    addr = a;
    len = l;
    cfg = c;
    valid = 1;
    @(negedge clk);
    valid = 0;
    fork
      feed();
      for (n = 0; n < 40000 && done !== 1'b1; n++) @(negedge clk);
    join
    `CHK("done", 1'b1, done)
  endtask
  task automatic s_lockout();
    run(OP_LOCKOUT, 16'h0000, 0, 0);
    e(1, 0, `GBS_CMD_LLO);
    cmp("lockout");
  endtask
  task automatic s_short();
    @(negedge clk);
    e_len = 4'h1;
    e_str = 64'h21;
    eol_wr = 1;
    @(negedge clk);
    eol_wr = 0;
    sq = '{8'h41, 8'h42};
    run(OP_SHORT, 16'h0003, 0, 0);
    ad(8'h03);
    e(0, 0, 8'h41);
    e(0, 0, 8'h42);
    e(0, 1, 8'h21);
    cmp("short");
    `CHK("ren", 1'b0, ren_n)
  endtask
  task automatic s_local();
    run(OP_LOCAL, 16'h001E, 0, 0);
    ad(8'h1E);
    e(1, 0, `GBS_CMD_GTL);
    cmp("gtl");
    run(OP_LOCAL, 16'h001F, 0, 0);
    cmp("release");
    `CHK("ren", 2'b11, {ren_n, atn_n})
  endtask
  task automatic s_long();
    slow = 1;
    run(OP_LONG, 16'h0007, 16'h0003, 0);
    ad(8'h07);
    for (int k = 0; k < 3; k++) e(0, 0, 8'h30 + k[7:0]);
    cmp("long");
    `CHK("count", 16'h0003, cnt)
    `CHK("seg", 16'h4000, m_seg)
    slow = 0;
    run(OP_LONG, 16'h8000, 16'h0002, 0);
    e(0, 0, 8'h30);
    e(0, 0, 8'h31);
    cmp("long_any");
  endtask
  task automatic s_timeout();
    stall = 1;
    tmo = 16'h0008;
    run(OP_LONG, 16'h0007, 16'h0003, 0);
    `CHK("error", `GBS_ERR_TIMEOUT, err)
    `CHK("stalled", 1, u_bus.log_q.size())
    `CHK("count", 16'h0000, cnt)
    stall = 0;
    tmo = 16'h0100;
    repeat (100) @(negedge clk);
  endtask
  task automatic s_ppc();
    run(OP_POLL_CFG, 16'h0009, 0, 16'hFFF9);
    ad(8'h09);
    e(1, 0, `GBS_CMD_PPC);
    e(1, 0, `GBS_PPE_BASE | 8'h09);
    cmp("ppc");
    `CHK("error", `GBS_ERR_NONE, err)
    run(OP_POLL_CFG, 16'hFFFF, 0, 16'h0003);
    e(1, 0, `GBS_CMD_PPC);
    e(1, 0, `GBS_PPE_BASE | 8'h03);
    cmp("ppc_any");
  endtask
  task automatic s_modes();
    for (int m = 0; m < 3; m++) begin
      @(negedge clk);
      t_addr = 5'h1F;
      t_mode = m[1:0];
      term_wr = 1;
      @(negedge clk);
      term_wr = 0;
      sq = '{8'h41};
      run(OP_SHORT, 16'hFFFF, 0, 0);
      e(0, m == 1, 8'h41);
      if (m != 1) e(0, 0, 8'h21);
      if (m == 0) eq[1][8] = 1'b1;
      cmp("mode");
    end
  endtask
  task automatic s_poll();
    ppr = 8'hA5;
    @(posedge clk);
    ce = 0;
    ca = 0;
    run(OP_POLL, 0, 0, 0);
    `CHK("poll", 8'hA5, pres)
    `CHK("hold", 1'b1, ce >= 625)
    `CHK("order", 1'b1, ca > ce)
    `CHK("release", 2'b11, {atn_n, eoi_n})
  endtask
  task automatic conclude();
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #3000000;
    errors++;
    conclude();
  end
  initial begin
    repeat (2) @(negedge clk);
    rst_n = 1;
    repeat (3) @(negedge clk);
    s_lockout();
    s_short();
    s_local();
    s_long();
    s_timeout();
    s_ppc();
    s_modes();
    s_poll();
    conclude();
  end
endmodule // tb_ieee488_bus_command_sequencer

/* verilog/gbs_handshake.sv */
// Source handshake for one bus byte, with timeout
`timescale 1ns/10ps
`include "gbs_map.svh"
module gbs_handshake import gbs_pkg::*; #(
  parameter int unsigned UNIT_CYCLES = `GBS_TIMEOUT_UNIT_CYCLES
) (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Byte request
  input wire logic i_start,
  input wire logic [7:0] i_byte,
  input wire logic i_eoi,
  input wire logic [15:0] i_timeout,
  // Filtered bus levels
  input wire logic i_nrfd_n,
  input wire logic i_ndac_n,
  // Result
  output logic o_idle,
  output logic o_dav,
  output logic o_eoi,
  output logic [7:0] o_data,
  output logic o_done,
  output logic o_timeout
);
  localparam logic [7:0] SETTLE_LAST = 8'(`GBS_SETTLE_CYCLES - 1);
  localparam logic [31:0] UNIT_LAST = 32'(UNIT_CYCLES - 1);

  gbs_hs_state_type state;
  logic [7:0] settle_cnt;
  logic [31:0] unit_cnt;
  logic [15:0] units;

  wire unit_tick = (unit_cnt == UNIT_LAST);
  wire expired = (i_timeout != 16'h0000) && (units == i_timeout) && (state != HS_IDLE);

  assign o_idle = (state == HS_IDLE);

  // Timeout units since the byte was started
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      unit_cnt <= 32'h0000_0000;
      units <= 16'h0000;
    end else if (i_clk_en) begin
      if (state == HS_IDLE) begin
        unit_cnt <= 32'h0000_0000;
        units <= 16'h0000;
      end else if (unit_tick) begin
        unit_cnt <= 32'h0000_0000;
        units <= units + 16'h0001;
      end else begin
        unit_cnt <= unit_cnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= HS_IDLE;
      settle_cnt <= 8'h00;
      o_dav <= 1'b0;
      o_eoi <= 1'b0;
      o_data <= 8'h00;
      o_done <= 1'b0;
      o_timeout <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      o_timeout <= 1'b0;
      if (expired) begin
        state <= HS_IDLE;
        o_dav <= 1'b0;
        o_eoi <= 1'b0;
        o_timeout <= 1'b1;
      end else begin
        case (state)
          HS_IDLE: if (i_start) begin
            o_data <= i_byte;
            o_eoi <= i_eoi;
            state <= HS_WAIT_RFD;
          end
          HS_WAIT_RFD: if (i_nrfd_n) begin
            settle_cnt <= 8'h00;
            state <= HS_SETTLE;
          end
          HS_SETTLE: if (settle_cnt == SETTLE_LAST) begin
            o_dav <= 1'b1;
            state <= HS_WAIT_ACC;
          end else begin
            settle_cnt <= settle_cnt + 8'h01;
          end
          HS_WAIT_ACC: if (i_ndac_n) begin
            o_dav <= 1'b0;
            o_eoi <= 1'b0;
            o_done <= 1'b1;
            state <= HS_IDLE;
          end
          default: state <= HS_IDLE;
        endcase
      end
    end
  end
endmodule // gbs_handshake

/* verilog/gbs_map.svh */
// Bus command codes, timing figures and defaults for the bus command sequencer
`ifndef GBS_MAP_SVH
`define GBS_MAP_SVH

// Clock rate
`define GBS_CLK_HZ 25000000
`define GBS_CLK_MHZ 25

// Universal and addressed bus commands
`define GBS_CMD_UNL 8'h3F
`define GBS_CMD_LLO 8'h11
`define GBS_CMD_GTL 8'h01
`define GBS_CMD_PPC 8'h05
`define GBS_LISTEN_BASE 8'h20
`define GBS_TALK_BASE 8'h40
`define GBS_PPE_BASE 8'h60
`define GBS_PPE_CFG_W 4

// Device address range
`define GBS_MAX_ADDR 16'h001E
`define GBS_GLOBAL_SLOT 5'h1F

// Output terminator modes
`define GBS_TERM_BOTH 2'h0
`define GBS_TERM_EOI 2'h1
`define GBS_TERM_STR 2'h2

// End-of-line string: up to 8 bytes, default CR LF
`define GBS_EOL_MAX 4'h8
`define GBS_EOL_DEF_LEN 4'h2
`define GBS_EOL_DEF_STR 64'h0000_0000_0000_0A0D

// Error codes
`define GBS_ERR_NONE 3'h0
`define GBS_ERR_TIMEOUT 3'h1

// Parallel poll hold, 25 us, rounded up
`define GBS_POLL_NS 25000
`define GBS_POLL_CYCLES ((`GBS_POLL_NS * `GBS_CLK_MHZ + 999) / 1000)
// Data settling before the data-valid strobe, 2 us, rounded up
`define GBS_SETTLE_NS 2000
`define GBS_SETTLE_CYCLES ((`GBS_SETTLE_NS * `GBS_CLK_MHZ + 999) / 1000)
// Timeout unit, 1 ms
`define GBS_TIMEOUT_UNIT_NS 1000000
`define GBS_TIMEOUT_UNIT_CYCLES ((`GBS_TIMEOUT_UNIT_NS / 1000) * `GBS_CLK_MHZ)

`endif

/* verilog/gbs_pkg.sv */
// Types shared by the bus command sequencer
package gbs_pkg;
  typedef enum logic [2:0] {
    OP_LOCKOUT, OP_LOCAL, OP_SHORT, OP_LONG, OP_POLL, OP_POLL_CFG
  } gbs_op_type;
  typedef enum logic [3:0] {
    ST_IDLE, ST_CMD, ST_DATA, ST_TERM, ST_LONG_FETCH, ST_LONG_SEND, ST_POLL, ST_ATN_OFF, ST_FINISH
  } gbs_state_type;
  typedef enum logic [2:0] {
    HS_IDLE, HS_WAIT_RFD, HS_SETTLE, HS_WAIT_ACC
  } gbs_hs_state_type;
endpackage

/* verilog/gbs_sequencer.sv */
// Controller-side bus command sequencer: addressing, strings, parallel poll
// Notes on behaviour
// - Lockout asserts ATN then sends the universal lockout command, no address.
// - Go-to-local in 0..30: ATN, unlisten, listen address, own talk, go-to-local.
// - Go-to-local outside 0..30: release REN, then ATN, no command bytes.
// - Released REN is driven electrically high.
// - Short string in range: ATN, REN, addressing, drop ATN, data, terminator.
// - Short string out of range: no addressing, drop ATN, data, terminator.
// - After the last short data byte send the device's configured terminator.
// - Terminator mode 0 string plus EOI, 1 EOI alone, 2 string alone.
// - End-of-line string holds up to 8 bytes, default CR LF.
// - Long string sends 0..65535 bytes from a memory segment from offset zero.
// - Long string stops at the byte count or on a handshake timeout.
// - Long string in range: ATN, addressing, drop ATN, stream; no REN, no terminator.
// - Long string out of range: no addressing, drop ATN, stream bytes.
// - Poll: ATN and EOI for 25 us, capture data, release EOI then ATN.
// - Poll result is the eight captured data lines; configured devices drive them.
// - Poll configure in range: ATN, addressing, configure command, then enable byte.
// - Poll configure out of range: ATN, configure command, enable byte.
// - Configuration bits 4 to 15 are ignored.
`timescale 1ns/10ps
`include "gbs_map.svh"
module gbs_sequencer import gbs_pkg::*; #(
  parameter int unsigned TIMEOUT_UNIT_CYCLES = `GBS_TIMEOUT_UNIT_CYCLES
) (
  // Clock, reset, enable
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // Host operation request and result
  input wire logic i_cmd_valid,
  input gbs_op_type i_cmd_op,
  input wire logic [15:0] i_cmd_addr,
  input wire logic [15:0] i_cmd_seg,
  input wire logic [15:0] i_cmd_len,
  input wire logic [15:0] i_cmd_config,
  output logic o_cmd_ready,
  output logic o_done,
  output logic [2:0] o_error,
  output logic [7:0] o_poll_result,
  output logic [15:0] o_count,
  // Settings
  input wire logic [4:0] i_my_addr,
  input wire logic [15:0] i_timeout,
  input wire logic i_term_wr,
  input wire logic [4:0] i_term_addr,
  input wire logic [1:0] i_term_mode,
  input wire logic i_eol_wr,
  input wire logic [3:0] i_eol_len,
  input wire logic [63:0] i_eol_str,
  // Short string byte stream
  input wire logic i_data_valid,
  input wire logic [7:0] i_data_byte,
  input wire logic i_data_last,
  output logic o_data_ready,
  // Source segment reads
  output logic o_mem_req,
  output logic [15:0] o_mem_seg,
  output logic [15:0] o_mem_offset,
  input wire logic i_mem_ack,
  input wire logic [7:0] i_mem_data,
  // Bus pins, low true; data output enable o_dio_oe high true
  output logic o_atn_n,
  output logic o_ren_n,
  output logic o_eoi_n,
  output logic o_dav_n,
  output logic [7:0] o_dio_n,
  output logic o_dio_oe,
  input wire logic [7:0] i_dio_n,
  input wire logic i_nrfd_n,
  input wire logic i_ndac_n
);
  localparam logic [9:0] POLL_LAST = 10'(`GBS_POLL_CYCLES);

  function automatic logic addr_valid(input logic [15:0] a);
    addr_valid = !a[15] && (a <= `GBS_MAX_ADDR);
  endfunction

  function automatic logic [3:0] cmd_total(input gbs_op_type op, input logic ok);
    case (op)
      OP_LOCKOUT: cmd_total = 4'h1;
      OP_LOCAL: cmd_total = ok ? 4'h4 : 4'h0;
      OP_SHORT, OP_LONG: cmd_total = ok ? 4'h3 : 4'h0;
      OP_POLL_CFG: cmd_total = ok ? 4'h5 : 4'h2;
      default: cmd_total = 4'h0;
    endcase
  endfunction

  function automatic logic [7:0] cmd_byte(input gbs_op_type op, input logic ok, input logic [3:0] step,
                                          input logic [4:0] lad, input logic [4:0] me, input logic [3:0] cfg);
    logic [3:0] idx;
    idx = ok ? step : step + 4'h3;
    if (op == OP_LOCKOUT) begin
      cmd_byte = `GBS_CMD_LLO;
    end else begin
      case (idx)
        4'h0: cmd_byte = `GBS_CMD_UNL;
        4'h1: cmd_byte = `GBS_LISTEN_BASE | {3'h0, lad};
        4'h2: cmd_byte = `GBS_TALK_BASE | {3'h0, me};
        4'h3: cmd_byte = (op == OP_LOCAL) ? `GBS_CMD_GTL : `GBS_CMD_PPC;
        default: cmd_byte = `GBS_PPE_BASE | {4'h0, cfg};
      endcase
    end
  endfunction

  // Reset release and input filters
  logic rst_meta, rst_n;
  logic [9:0] pin_s1, pin_s2, pin_s3, pin_filt;
  wire [7:0] dio_filt = pin_filt[7:0];

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 10'h3FF;
      pin_s2 <= 10'h3FF;
      pin_s3 <= 10'h3FF;
      pin_filt <= 10'h3FF;
    end else if (i_clk_en) begin
      pin_s1 <= {i_ndac_n, i_nrfd_n, i_dio_n};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_filt <= (pin_s2 & pin_s3) | (pin_filt & (pin_s2 | pin_s3));
    end
  end

  // Terminator settings
  logic [1:0] term_tab [0:31];
  logic [3:0] eol_len;
  logic [63:0] eol_str;

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 32; i++) begin
        term_tab[i] <= `GBS_TERM_BOTH;
      end
      eol_len <= `GBS_EOL_DEF_LEN;
      eol_str <= `GBS_EOL_DEF_STR;
    end else if (i_clk_en) begin
      if (i_term_wr) begin
        term_tab[i_term_addr] <= i_term_mode;
      end
      if (i_eol_wr) begin
        eol_len <= (i_eol_len > `GBS_EOL_MAX) ? `GBS_EOL_MAX : i_eol_len;
        eol_str <= i_eol_str;
      end
    end
  end

  // Operation state
  gbs_state_type state;
  gbs_op_type op;
  logic addr_ok;
  logic [4:0] lad;
  logic [3:0] cfg;
  logic [15:0] len;
  logic [1:0] cur_mode;
  logic [3:0] total;
  logic [3:0] step;
  logic last_q;
  logic [7:0] long_byte;
  logic [9:0] poll_cnt;
  logic poll_eoi;
  logic hs_start, hs_wait, hs_eoi_q;
  logic [7:0] hs_byte_q;
  logic hs_idle, hs_dav, hs_eoi, hs_done, hs_timeout;
  logic [7:0] hs_data;

  wire take_cmd = o_cmd_ready & i_cmd_valid;
  wire take_data = o_data_ready & i_data_valid;
  wire cmd_ok = addr_valid(i_cmd_addr);
  wire [3:0] term_total = (cur_mode == `GBS_TERM_EOI) ? 4'h0 : eol_len;
  wire cmd_end = (state == ST_CMD) && (step == total) && !hs_wait;
  wire term_end = (state == ST_TERM) && (step == term_total) && !hs_wait;
  wire [15:0] next_offset = o_mem_offset + 16'h0001;
  wire free = hs_idle && !hs_wait && !hs_start;
  wire launch = free && (((state == ST_CMD) && (step != total)) || ((state == ST_TERM) && (step != term_total))
                         || (state == ST_LONG_SEND));
  wire [7:0] eol_byte = eol_str[{step[2:0], 3'h0} +: 8];
  wire [7:0] launch_byte = (state == ST_CMD) ? cmd_byte(op, addr_ok, step, lad, i_my_addr, cfg) :
                           (state == ST_TERM) ? eol_byte : long_byte;
  wire launch_eoi = (state == ST_TERM) && (cur_mode == `GBS_TERM_BOTH) && (step == term_total - 4'h1);
  wire data_eoi = i_data_last && (cur_mode == `GBS_TERM_EOI);
  wire needs_atn = (i_cmd_op == OP_LOCKOUT) || (i_cmd_op == OP_POLL) || (i_cmd_op == OP_POLL_CFG)
                   || ((i_cmd_op == OP_LOCAL) && cmd_ok);

  // Byte launch toward the handshake
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_start <= 1'b0;
      hs_wait <= 1'b0;
      hs_byte_q <= 8'h00;
      hs_eoi_q <= 1'b0;
      step <= 4'h0;
      last_q <= 1'b0;
      o_data_ready <= 1'b0;
    end else if (i_clk_en) begin
      hs_start <= launch || take_data;
      if (launch || take_data) begin
        hs_wait <= 1'b1;
        hs_byte_q <= take_data ? i_data_byte : launch_byte;
        hs_eoi_q <= take_data ? data_eoi : launch_eoi;
      end else if (hs_done || hs_timeout) begin
        hs_wait <= 1'b0;
      end
      if (take_data) begin
        last_q <= i_data_last;
      end
      o_data_ready <= !take_data && (state == ST_DATA) && free && !(hs_done && last_q) && !hs_timeout;
      if (take_cmd || cmd_end) begin
        step <= 4'h0;
      end else if (hs_done && ((state == ST_CMD) || (state == ST_TERM))) begin
        step <= step + 4'h1;
      end
    end
  end

  // Operation sequencing
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      op <= OP_LOCKOUT;
      addr_ok <= 1'b0;
      lad <= 5'h00;
      cfg <= 4'h0;
      len <= 16'h0000;
      cur_mode <= `GBS_TERM_BOTH;
      total <= 4'h0;
      long_byte <= 8'h00;
      poll_cnt <= 10'h000;
      poll_eoi <= 1'b0;
      o_cmd_ready <= 1'b1;
      o_done <= 1'b0;
      o_error <= `GBS_ERR_NONE;
      o_poll_result <= 8'h00;
      o_count <= 16'h0000;
      o_mem_req <= 1'b0;
      o_mem_seg <= 16'h0000;
      o_mem_offset <= 16'h0000;
      o_atn_n <= 1'b1;
      o_ren_n <= 1'b1;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      if (hs_done && ((state == ST_DATA) || (state == ST_LONG_SEND))) begin
        o_count <= o_count + 16'h0001;
      end
      if (hs_timeout) begin
        o_error <= `GBS_ERR_TIMEOUT;
        o_mem_req <= 1'b0;
        state <= ST_FINISH;
      end else begin
        case (state)
          ST_IDLE: if (take_cmd) begin
            o_cmd_ready <= 1'b0;
            op <= i_cmd_op;
            addr_ok <= cmd_ok;
            lad <= i_cmd_addr[4:0];
            cfg <= i_cmd_config[3:0];
            len <= i_cmd_len;
            o_mem_seg <= i_cmd_seg;
            o_mem_offset <= 16'h0000;
            cur_mode <= cmd_ok ? term_tab[i_cmd_addr[4:0]] : term_tab[`GBS_GLOBAL_SLOT];
            total <= cmd_total(i_cmd_op, cmd_ok);
            o_error <= `GBS_ERR_NONE;
            o_count <= 16'h0000;
            if (needs_atn) begin
              o_atn_n <= 1'b0;
            end
            if (((i_cmd_op == OP_SHORT) || (i_cmd_op == OP_LONG)) && cmd_ok) begin
              o_atn_n <= 1'b0;
            end
            if ((i_cmd_op == OP_SHORT) && cmd_ok) begin
              o_ren_n <= 1'b0;
            end
            if (i_cmd_op == OP_POLL) begin
              poll_eoi <= 1'b1;
              poll_cnt <= 10'h000;
              state <= ST_POLL;
            end else begin
              state <= ST_CMD;
            end
          end
          ST_CMD: if (cmd_end) begin
            case (op)
              OP_LOCAL: if (addr_ok) begin
                state <= ST_FINISH;
              end else begin
                o_ren_n <= 1'b1;
                state <= ST_ATN_OFF;
              end
              OP_SHORT: begin
                o_atn_n <= 1'b1;
                state <= ST_DATA;
              end
              OP_LONG: begin
                o_atn_n <= 1'b1;
                o_mem_req <= (len != 16'h0000);
                state <= (len == 16'h0000) ? ST_FINISH : ST_LONG_FETCH;
              end
              default: state <= ST_FINISH;
            endcase
          end
          ST_DATA: if (hs_done && last_q) begin
            state <= ST_TERM;
          end
          ST_TERM: if (term_end) begin
            state <= ST_FINISH;
          end
          ST_LONG_FETCH: if (i_mem_ack && o_mem_req) begin
            o_mem_req <= 1'b0;
            long_byte <= i_mem_data;
            state <= ST_LONG_SEND;
          end
          ST_LONG_SEND: if (hs_done) begin
            o_mem_offset <= next_offset;
            if (next_offset == len) begin
              state <= ST_FINISH;
            end else begin
              o_mem_req <= 1'b1;
              state <= ST_LONG_FETCH;
            end
          end
          ST_POLL: if (poll_cnt == POLL_LAST) begin
            o_poll_result <= ~dio_filt;
            poll_eoi <= 1'b0;
            state <= ST_ATN_OFF;
          end else begin
            poll_cnt <= poll_cnt + 10'h001;
          end
          ST_ATN_OFF: if (o_eoi_n) begin
            o_atn_n <= 1'b1;
            state <= ST_FINISH;
          end
          default: begin
            o_done <= 1'b1;
            o_cmd_ready <= 1'b1;
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Pin drivers
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_eoi_n <= 1'b1;
      o_dav_n <= 1'b1;
      o_dio_n <= 8'hFF;
      o_dio_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_eoi_n <= !(hs_eoi || poll_eoi);
      o_dav_n <= !hs_dav;
      o_dio_n <= ~hs_data;
      o_dio_oe <= !hs_idle;
    end
  end

  gbs_handshake #(
    .UNIT_CYCLES(TIMEOUT_UNIT_CYCLES)
  ) u_handshake (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_clk_en(i_clk_en),
    .i_start(hs_start),
    .i_byte(hs_byte_q),
    .i_eoi(hs_eoi_q),
    .i_timeout(i_timeout),
    .i_nrfd_n(pin_filt[8]),
    .i_ndac_n(pin_filt[9]),
    .o_idle(hs_idle),
    .o_dav(hs_dav),
    .o_eoi(hs_eoi),
    .o_data(hs_data),
    .o_done(hs_done),
    .o_timeout(hs_timeout)
  );

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!rst_n || !i_clk_en);

  sequence s_poll_end;
    (state == ST_POLL) && (poll_cnt == POLL_LAST);
  endsequence
  sequence s_release;
    (state == ST_ATN_OFF) && !o_atn_n ##1 o_eoi_n && !o_atn_n ##1 o_atn_n;
  endsequence

  a_lockout_byte: assert property (launch && (op == OP_LOCKOUT) |-> !o_atn_n && (launch_byte == `GBS_CMD_LLO))
    else $error("lockout byte wrong or ATN false");
  a_cmd_atn: assert property (launch && (state == ST_CMD) |-> !o_atn_n)
    else $error("command byte without ATN");
  a_local_release: assert property (cmd_end && (op == OP_LOCAL) && !addr_ok |=> o_ren_n ##1 o_atn_n)
    else $error("REN and ATN not released in order");
  a_data_no_atn: assert property ((state == ST_DATA) && take_data |-> o_atn_n)
    else $error("data byte with ATN true");
  a_term_mode: assert property (launch && (state == ST_TERM) |-> (cur_mode != `GBS_TERM_EOI)
                                && (launch_eoi == ((cur_mode == `GBS_TERM_BOTH) && (step == eol_len - 4'h1))))
    else $error("terminator byte against mode");
  a_long_stop: assert property ((state == ST_LONG_SEND) && hs_done && (next_offset == len) |=> state == ST_FINISH
                                ##1 o_done)
    else $error("long string did not stop at count");
  a_long_plain: assert property (launch && (state == ST_LONG_SEND) |=> !hs_eoi_q && $stable(o_ren_n))
    else $error("long string added terminator or REN");
  a_poll_order: assert property (s_poll_end |=> s_release)
    else $error("poll release order wrong");
  a_poll_hold: assert property ((state == ST_POLL) && (poll_cnt > 10'h001) |-> !o_eoi_n && !o_atn_n)
    else $error("ATN or EOI dropped during poll");
  a_ppe_byte: assert property (launch && (op == OP_POLL_CFG) && (step == total - 4'h1)
                               |-> launch_byte == (`GBS_PPE_BASE | {4'h0, cfg}))
    else $error("poll enable byte wrong");
  a_timeout_abort: assert property (hs_timeout |=> (state == ST_FINISH) && (o_error == `GBS_ERR_TIMEOUT)
                                    ##1 o_done)
    else $error("timeout did not abort");
endmodule // gbs_sequencer
